/* fseq_pkg.sv */
// Purpose: Shared constants for the four rail power sequencer.
// Assumes: 50 MHz core clock.
// Notes:   Timer counts are derived from times in microseconds.
package fseq_pkg;
    localparam int CLK_MHZ           = 50;
    localparam int NUM_RAILS         = 4;
    localparam int TIMER_WIDTH       = 21;
    // Step delay range ends, in microseconds.
    localparam int STEP_MIN_US       = 250;
    localparam int STEP_MAX_US       = 25000;
    localparam int STEP_MIN_CYCLES   = STEP_MIN_US * CLK_MHZ;
    localparam int STEP_MAX_CYCLES   = STEP_MAX_US * CLK_MHZ;
    // Default settle timeout, in microseconds.
    localparam int SETTLE_DEF_US     = 264;
    localparam int SETTLE_DEF_CYCLES = SETTLE_DEF_US * CLK_MHZ;
    localparam logic [1:0] FIRST_RAIL = 2'h0;
    localparam logic [1:0] LAST_RAIL  = 2'h3;
    localparam logic [1:0] RAIL_STEP  = 2'h1;

    typedef enum logic [2:0] {
        FSEQ_OFF,
        FSEQ_UP_DELAY,
        FSEQ_UP_SETTLE,
        FSEQ_ON,
        FSEQ_DN_DELAY,
        FSEQ_DN_WAIT
    } fseq_state_type;
endpackage

/* fseq_timer.sv */
// Purpose: Down counter that flags when a programmed count has elapsed.
// Assumes: Terminal count of zero means expire on the first counted cycle.
// Notes:   Restart reloads the count; done holds until the next restart.
`timescale 1ns/1ps
module fseq_timer #(
    parameter int WIDTH = 21
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             clk_en,
    input  wire logic             restart,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] terminal,
    output logic                  done
);
    logic [WIDTH-1:0] count_q;
    logic             armed_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
            armed_q <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                count_q <= terminal;
                armed_q <= 1'b1;
            end else if (run && armed_q && count_q != '0) begin
                count_q <= count_q - WIDTH'(1);
            end
        end
    end

    assign done = armed_q && !restart && count_q == '0;
endmodule // fseq_timer

/* fseq_core.sv */
// Purpose: Four rail power sequencer with up and down command edges.
// Assumes: Monitor inputs are comparator levels from outside the clock.
// Notes:   Reset is the supply low lockout; counts are software-free ports.
`timescale 1ns/1ps
module fseq_core #(
    parameter int                    TW         = fseq_pkg::TIMER_WIDTH,
    parameter logic [TW-1:0]         STEP_DEF   = TW'(fseq_pkg::STEP_MIN_CYCLES),
    parameter logic [TW-1:0]         SETTLE_DEF = TW'(fseq_pkg::SETTLE_DEF_CYCLES)
) (
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          clk_en,
    input  wire logic          up_cmd,
    input  wire logic          down_cmd_n,
    input  wire logic [3:0]    rail_monitor_in,
    input  wire logic [3:0]    rail_tied_high,
    input  wire logic [TW-1:0] step_delay_cycles,
    input  wire logic [TW-1:0] settle_timeout_cycles,
    output logic [3:0]         rail_enable_out,
    output logic               sequence_complete,
    output logic               rails_good
);
    fseq_pkg::fseq_state_type state_q;
    logic [1:0] rail_q;
    logic [3:0] mon_meta_q, mon_q, skip_meta_q, skip_sync_q, skip_q;
    logic       up_meta_q, up_sync_q, up_prev_q;
    logic       dn_meta_q, dn_sync_q, dn_prev_q;
    logic       skip_taken_q;
    logic [1:0] skip_age_q;
    logic       up_edge, dn_edge;
    logic [1:0] last_used;
    logic       step_restart, step_run, step_done;
    logic       settle_restart, settle_run, settle_done;
    logic [TW-1:0] step_term;

    // Highest rail that takes part; a skipped rail removes all above it.
    function automatic logic [1:0] last_rail(input logic [3:0] skip);
        logic [1:0] r;
        r = fseq_pkg::LAST_RAIL;
        for (int i = 3; i >= 1; i--) begin
            if (skip[i]) begin
                r = 2'(i - 1);
            end
        end
        return r;
    endfunction

    // Step delay clamped into its legal range.
    function automatic logic [TW-1:0] clamp(input logic [TW-1:0] v);
        if (v < TW'(fseq_pkg::STEP_MIN_CYCLES)) begin
            return TW'(fseq_pkg::STEP_MIN_CYCLES);
        end else if (v > TW'(fseq_pkg::STEP_MAX_CYCLES)) begin
            return TW'(fseq_pkg::STEP_MAX_CYCLES);
        end
        return v;
    endfunction

    // Two flops for every monitor, strap and command pin before any logic reads it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mon_meta_q  <= 4'h0;
            mon_q       <= 4'h0;
            skip_meta_q <= 4'h0;
            skip_sync_q <= 4'h0;
            up_meta_q   <= 1'b0;
            up_sync_q   <= 1'b0;
            dn_meta_q   <= 1'b1;
            dn_sync_q   <= 1'b1;
        end else if (clk_en) begin
            mon_meta_q  <= rail_monitor_in;
            mon_q       <= mon_meta_q;
            skip_meta_q <= rail_tied_high;
            skip_sync_q <= skip_meta_q;
            up_meta_q   <= up_cmd;
            up_sync_q   <= up_meta_q;
            dn_meta_q   <= down_cmd_n;
            dn_sync_q   <= dn_meta_q;
        end
    end

    // Previous levels start at the active value; a pin held active through release still shows an edge two cycles later.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            up_prev_q <= 1'b1;
            dn_prev_q <= 1'b0;
        end else if (clk_en) begin
            up_prev_q <= up_sync_q;
            dn_prev_q <= dn_sync_q;
        end
    end

    assign up_edge = up_sync_q && !up_prev_q;
    assign dn_edge = !dn_sync_q && dn_prev_q;

    // The skip set is caught once after lockout and then frozen. The age
    // shift waits until the strap synchroniser holds real pin values.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            skip_q       <= 4'h0;
            skip_taken_q <= 1'b0;
            skip_age_q   <= 2'h0;
        end else if (clk_en) begin
            skip_age_q <= {skip_age_q[0], 1'b1};
            if (!skip_taken_q && skip_age_q[1]) begin
                skip_q       <= {skip_sync_q[3:1], 1'b0};
                skip_taken_q <= 1'b1;
            end
        end
    end

    assign last_used = last_rail(skip_q);
    assign step_term = clamp(step_delay_cycles);

    // Step timer restarts whenever a state with a step wait is entered.
    assign step_restart = clk_en && (up_edge && state_q == fseq_pkg::FSEQ_OFF
        || dn_edge && state_q != fseq_pkg::FSEQ_OFF
        || state_q == fseq_pkg::FSEQ_UP_SETTLE && mon_q[rail_q]
        || state_q == fseq_pkg::FSEQ_DN_WAIT && !mon_q[rail_q]
        || state_q == fseq_pkg::FSEQ_UP_SETTLE && settle_done);
    assign step_run = state_q == fseq_pkg::FSEQ_UP_DELAY
        || state_q == fseq_pkg::FSEQ_DN_DELAY;
    assign settle_restart = clk_en && state_q == fseq_pkg::FSEQ_UP_DELAY
        && step_done;
    assign settle_run = state_q == fseq_pkg::FSEQ_UP_SETTLE;

    fseq_timer #(.WIDTH(TW)) u_step (
        .clk      (clk),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .restart  (step_restart),
        .run      (step_run),
        .terminal (step_term),
        .done     (step_done)
    );

    fseq_timer #(.WIDTH(TW)) u_settle (
        .clk      (clk),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .restart  (settle_restart),
        .run      (settle_run),
        .terminal (settle_timeout_cycles),
        .done     (settle_done)
    );

    // Sequencing state; lockout reset clears everything to off.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= fseq_pkg::FSEQ_OFF;
            rail_q  <= fseq_pkg::FIRST_RAIL;
        end else if (clk_en) begin
            if (dn_edge && state_q != fseq_pkg::FSEQ_OFF) begin
                state_q <= fseq_pkg::FSEQ_DN_DELAY;
                rail_q  <= last_used;
            end else begin
                case (state_q)
                    fseq_pkg::FSEQ_OFF: begin
                        if (up_edge) begin
                            state_q <= fseq_pkg::FSEQ_UP_DELAY;
                            rail_q  <= fseq_pkg::FIRST_RAIL;
                        end
                    end
                    fseq_pkg::FSEQ_UP_DELAY: begin
                        if (step_done) begin
                            state_q <= fseq_pkg::FSEQ_UP_SETTLE;
                        end
                    end
                    fseq_pkg::FSEQ_UP_SETTLE: begin
                        if (mon_q[rail_q]) begin
                            if (rail_q == last_used) begin
                                state_q <= fseq_pkg::FSEQ_ON;
                            end else begin
                                state_q <= fseq_pkg::FSEQ_UP_DELAY;
                                rail_q  <= rail_q + fseq_pkg::RAIL_STEP;
                            end
                        end else if (settle_done) begin
                            // Abort: the failing rail drops at once, and the
                            // reverse sequence starts from the rail beneath.
                            if (rail_q == fseq_pkg::FIRST_RAIL) begin
                                state_q <= fseq_pkg::FSEQ_OFF;
                            end else begin
                                state_q <= fseq_pkg::FSEQ_DN_DELAY;
                                rail_q  <= rail_q - fseq_pkg::RAIL_STEP;
                            end
                        end
                    end
                    fseq_pkg::FSEQ_ON: begin
                        state_q <= fseq_pkg::FSEQ_ON;
                    end
                    fseq_pkg::FSEQ_DN_DELAY: begin
                        if (step_done) begin
                            state_q <= fseq_pkg::FSEQ_DN_WAIT;
                        end
                    end
                    fseq_pkg::FSEQ_DN_WAIT: begin
                        if (!mon_q[rail_q]) begin
                            if (rail_q == fseq_pkg::FIRST_RAIL) begin
                                rail_q  <= fseq_pkg::FIRST_RAIL;
                                state_q <= fseq_pkg::FSEQ_OFF;
                            end else begin
                                state_q <= fseq_pkg::FSEQ_DN_DELAY;
                                rail_q  <= rail_q - fseq_pkg::RAIL_STEP;
                            end
                        end
                    end
                    default: begin
                        state_q <= fseq_pkg::FSEQ_OFF;
                    end
                endcase
            end
        end
    end

    // Enables: raised on step expiry up, lowered on step expiry down.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rail_enable_out <= 4'h0;
        end else if (clk_en) begin
            if (state_q == fseq_pkg::FSEQ_UP_DELAY && step_done) begin
                rail_enable_out[rail_q] <= 1'b1;
            end else if (state_q == fseq_pkg::FSEQ_DN_DELAY && step_done) begin
                rail_enable_out[rail_q] <= 1'b0;
            end else if (state_q == fseq_pkg::FSEQ_UP_SETTLE && settle_done
                         && !mon_q[rail_q]) begin
                rail_enable_out[rail_q] <= 1'b0;
            end
        end
    end

    // Completion flag rises on reaching on, falls when rail 1 is done.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sequence_complete <= 1'b0;
        end else if (clk_en) begin
            if (state_q == fseq_pkg::FSEQ_UP_SETTLE && mon_q[rail_q]
                && rail_q == last_used && !dn_edge) begin
                sequence_complete <= 1'b1;
            end else if (state_q == fseq_pkg::FSEQ_DN_WAIT && !mon_q[rail_q]
                         && rail_q == fseq_pkg::FIRST_RAIL) begin
                sequence_complete <= 1'b0;
            end
        end
    end

    // Good drops on the very command edge, with no step wait.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rails_good <= 1'b0;
        end else if (clk_en) begin
            if (dn_edge) begin
                rails_good <= 1'b0;
            end else if (state_q == fseq_pkg::FSEQ_UP_SETTLE && mon_q[rail_q]
                         && rail_q == last_used) begin
                rails_good <= 1'b1;
            end
        end
    end
endmodule // fseq_core

/* fseq_rail_model.sv */
// Purpose: Regulator stand-in that reports regulation after a lag.
// Assumes: Rails rise quickly and discharge slowly.
// Notes:   A rail marked failing and not tied high never reaches regulation.
`timescale 1ns/1ps
module fseq_rail_model #(
    parameter int RISE_LAG = 5,
    parameter int FALL_LAG = 100
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] rail_enable_out,
    input  wire logic [3:0] rail_fail,
    input  wire logic [3:0] rail_tied_high,
    output logic      [3:0] rail_monitor_in
);
    logic [7:0] lag_q [4];
    logic [3:0] mon_q;
    logic [3:0] goal;
    assign goal = rail_enable_out & ~rail_fail;
    // Tied rails read as in regulation at all times.
    assign rail_monitor_in = mon_q | rail_tied_high;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mon_q <= 4'h0;
            for (int i = 0; i < 4; i++) lag_q[i] <= 8'h00;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (goal[i] == mon_q[i]) begin
                    lag_q[i] <= 8'h00;
                end else if (lag_q[i] == (goal[i] ? RISE_LAG : FALL_LAG)) begin
                    mon_q[i] <= goal[i];
                end else begin
                    lag_q[i] <= lag_q[i] + 8'h01;
                end
            end
        end
    end
endmodule // fseq_rail_model

/* fseq_core_properties.sv */
// Purpose: Port level timing relations of the sequencer core.
// Assumes: One clock domain; arst_n is the lockout reset.
// Notes:   Up command age is counted from the raw pin edge.
`timescale 1ns/1ps
module fseq_core_properties #(
    parameter int TW = fseq_pkg::TIMER_WIDTH
) (
    input wire logic          clk,
    input wire logic          arst_n,
    input wire logic          clk_en,
    input wire logic          up_cmd,
    input wire logic          down_cmd_n,
    input wire logic [3:0]    rail_monitor_in,
    input wire logic [3:0]    rail_tied_high,
    input wire logic [TW-1:0] step_delay_cycles,
    input wire logic [TW-1:0] settle_timeout_cycles,
    input wire logic [3:0]    rail_enable_out,
    input wire logic          sequence_complete,
    input wire logic          rails_good
);
    logic          up_prev_q;
    logic          up_seen_q;
    logic [TW-1:0] up_age_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            up_prev_q <= 1'b0;
            up_seen_q <= 1'b0;
            up_age_q  <= '0;
        end else begin
            up_prev_q <= up_cmd;
            if (up_cmd && !up_prev_q) begin
                up_seen_q <= 1'b1;
                up_age_q  <= '0;
            end else if (up_age_q != '1) begin
                up_age_q <= up_age_q + 1'b1;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_down_cmd;
        $fell(down_cmd_n) && rails_good;
    endsequence
    property p_lock_clear;
        $rose(arst_n) |-> rail_enable_out == 4'h0 && !rails_good
            && !sequence_complete;
    endproperty
    property p_wait_up;
        rail_enable_out != 4'h0 |-> up_seen_q;
    endproperty
    property p_step_min;
        $rose(rail_enable_out[0])
            |-> up_age_q >= TW'(fseq_pkg::STEP_MIN_CYCLES);
    endproperty
    property p_up_order;
        $rose(rail_enable_out[1]) |-> rail_enable_out[0] && rail_monitor_in[0];
    endproperty
    property p_down_order;
        $fell(rail_enable_out[0]) |-> rail_enable_out[3:1] == 3'h0;
    endproperty
    property p_done_rise;
        $rose(sequence_complete) |-> rails_good && rail_monitor_in[0];
    endproperty
    property p_good_drop;
        s_down_cmd |-> ##[1:6] !rails_good;
    endproperty
    property p_done_fall;
        $fell(sequence_complete) |-> rail_enable_out == 4'h0 && !rails_good;
    endproperty
    property p_skip;
        rail_tied_high[1] |-> rail_enable_out[3:1] == 3'h0;
    endproperty
    a_lock_clear: assert property (p_lock_clear)
        else $error("outputs not clear after lockout");
    a_wait_up: assert property (p_wait_up)
        else $error("enable without up command");
    a_step_min: assert property (p_step_min)
        else $error("first enable before step delay");
    a_up_order: assert property (p_up_order)
        else $error("rail 2 enabled before rail 1 regulates");
    a_down_order: assert property (p_down_order)
        else $error("rail 1 dropped before upper rails");
    a_done_rise: assert property (p_done_rise)
        else $error("complete without good and regulation");
    a_good_drop: assert property (p_good_drop)
        else $error("good not dropped on down command");
    a_done_fall: assert property (p_done_fall)
        else $error("complete dropped with rails still enabled");
    a_skip: assert property (p_skip)
        else $error("skipped rail enabled");
endmodule // fseq_core_properties
bind fseq_core fseq_core_properties #(.TW(TW)) u_fseq_core_properties (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .up_cmd(up_cmd),
    .down_cmd_n(down_cmd_n), .rail_monitor_in(rail_monitor_in),
    .rail_tied_high(rail_tied_high), .step_delay_cycles(step_delay_cycles),
    .settle_timeout_cycles(settle_timeout_cycles),
    .rail_enable_out(rail_enable_out), .sequence_complete(sequence_complete),
    .rails_good(rails_good));

/* fseq_core_tb.sv */
// Purpose: Directed sequences up, down and through a settle timeout.
// Assumes: Shortest step delay; the start-up wait is shortened.
// Notes:   Each test resets with its own skip straps.
`timescale 1ns/1ps
module fseq_core_tb;
    localparam int TW     = fseq_pkg::TIMER_WIDTH;
    localparam int STEP   = fseq_pkg::STEP_MIN_CYCLES;
    localparam int SETTLE = 50;
    logic       clk, arst_n, clk_en, up_cmd, down_cmd_n;
    logic [3:0] rail_monitor_in, rail_tied_high, rail_fail, rail_enable_out;
    logic       sequence_complete, rails_good;
    int         error_cnt, checks_done, cyc;
    fseq_core u_fseq_core (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .up_cmd(up_cmd), .down_cmd_n(down_cmd_n),
        .rail_monitor_in(rail_monitor_in), .rail_tied_high(rail_tied_high),
        .step_delay_cycles(TW'(STEP)), .settle_timeout_cycles(TW'(SETTLE)),
        .rail_enable_out(rail_enable_out),
        .sequence_complete(sequence_complete), .rails_good(rails_good));
    fseq_rail_model u_fseq_rail_model (.clk(clk), .arst_n(arst_n),
        .rail_enable_out(rail_enable_out), .rail_fail(rail_fail),
        .rail_tied_high(rail_tied_high), .rail_monitor_in(rail_monitor_in));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            $display("wrong value at %0t: run too long", $time);
            conclude();
        end
    end
    task chk(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    function automatic logic pick(input int idx);
        return (idx < 4) ? rail_enable_out[idx] : sequence_complete;
    endfunction
    task wait_bit(input int idx, input logic val, input int lim,
                  output int n);
        n = 0;
        while (pick(idx) !== val && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task do_reset(input logic [3:0] tied);
        @(negedge clk);
        arst_n = 1'b0;
        up_cmd = 1'b0;
        down_cmd_n = 1'b1;
        rail_tied_high = tied;
        rail_fail = 4'h0;
        repeat (5) @(negedge clk);
        chk(rail_enable_out === 4'h0 && sequence_complete === 1'b0
            && rails_good === 1'b0, "outputs during lockout");
        arst_n = 1'b1;
        // The start-up wait is shortened to keep the run short.
        repeat (20) @(negedge clk);
    endtask
    task test_up_down;
        int n;
        do_reset(4'h2);
        down_cmd_n = 1'b0;
        repeat (10) @(negedge clk);
        down_cmd_n = 1'b1;
        repeat (10) @(negedge clk);
        chk(rail_enable_out === 4'h0, "down edge in off acted");
        up_cmd = 1'b1;
        wait_bit(0, 1'b1, STEP + 20, n);
        chk(n >= STEP && n <= STEP + 8, "first enable delay");
        wait_bit(4, 1'b1, 200, n);
        chk(rail_enable_out === 4'h1 && rails_good === 1'b1,
            "complete with rail 1 only");
        up_cmd = 1'b0;
        repeat (5) @(negedge clk);
        up_cmd = 1'b1;
        repeat (50) @(negedge clk);
        chk(rail_enable_out === 4'h1 && sequence_complete === 1'b1,
            "up edge while on acted");
        down_cmd_n = 1'b0;
        repeat (6) @(negedge clk);
        chk(rails_good === 1'b0 && rail_enable_out === 4'h1,
            "good drop on down");
        wait_bit(0, 1'b0, STEP + 20, n);
        chk(n >= STEP - 6 && n <= STEP + 8, "down step delay");
        wait_bit(4, 1'b0, 2 * STEP, n);
        chk(n >= 100 && pick(4) === 1'b0, "complete fall");
        $display("test up down done");
    endtask
    task test_timeout;
        int n;
        do_reset(4'h0);
        rail_fail = 4'h2;
        up_cmd = 1'b1;
        wait_bit(1, 1'b1, 2 * STEP + 200, n);
        chk(rail_enable_out === 4'h3, "rail 2 after rail 1");
        clk_en = 1'b0;
        repeat (100) @(negedge clk);
        chk(rail_enable_out === 4'h3,
            "settle frozen by clock enable");
        clk_en = 1'b1;
        wait_bit(1, 1'b0, SETTLE + 20, n);
        chk(n >= SETTLE - 2 && n <= SETTLE + 10, "settle timeout");
        wait_bit(0, 1'b0, STEP + 20, n);
        chk(n >= STEP - 5 && n <= STEP + 8 && rail_enable_out === 4'h0
            && sequence_complete === 1'b0 && rails_good === 1'b0,
            "reverse down from rail 1");
        $display("test timeout done");
    endtask
    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        up_cmd = 1'b0;
        down_cmd_n = 1'b1;
        rail_tied_high = 4'h0;
        rail_fail = 4'h0;
        error_cnt = 0;
        checks_done = 0;
        cyc = 0;
        test_up_down();
        test_timeout();
        conclude();
    end
endmodule // fseq_core_tb
